//--- bench/lsu_properties.sv
// Checker of fault, bus and byte-operation behaviour at the load/store unit ports.
module lsu_properties (
  // Clock and reset.
  input wire logic                   sys_clk,
  input wire logic                   sys_rst,
  // Core side.
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire lsu_pkg::req_op_type    req_op,
  input wire logic [31:0]            req_addr,
  input wire logic                   rsp_valid,
  input wire logic                   align_fault,
  input wire lsu_pkg::rev_op_type    rev_op,
  input wire logic [31:0]            rev_in,
  input wire logic [31:0]            rev_out,
  // Memory bus.
  input wire logic                   mem_req,
  input wire logic                   mem_gnt,
  input wire logic [31:0]            mem_addr,
  input wire logic                   mem_write,
  input wire logic [3:0]             mem_be,
  input wire lsu_pkg::mem_kind_type  mem_kind,
  input wire logic                   mem_share,
  input wire lsu_pkg::cache_pol_type mem_cache,
  input wire logic                   mem_rvalid
);
  import lsu_pkg::*;
  logic take;
  logic bad;
  // A taken request, and whether its address breaks natural alignment.
  assign take = req_valid && req_ready;
  assign bad  = (req_op >= op_word_load) ? (req_addr[1:0] != 2'h0) : (req_op >= op_halfword_load && req_addr[0]);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Steps of a faulting request and of a bus request waiting for grant.
  sequence s_bad_take;
    take && bad;
  endsequence
  sequence s_gnt_wait;
    mem_req && !mem_gnt;
  endsequence
  a_fault_flag: assert property (s_bad_take |=> align_fault && !mem_req)
    else $error("Misaligned not faulted.");
  a_no_false_fault: assert property (take && !bad |=> !align_fault)
    else $error("Aligned faulted.");
  a_req_holds: assert property (s_gnt_wait |=> mem_req && $stable(mem_addr) && $stable(mem_be))
    else $error("Request moved before grant.");
  a_strong_shared: assert property (mem_req && mem_kind == mem_strong |-> mem_share)
    else $error("Strong not shareable.");
  a_io_uncached: assert property (mem_req && mem_kind != mem_normal |-> mem_cache == cache_none)
    else $error("Device or strong cached.");
  a_kind_legal: assert property (mem_req |-> mem_kind inside {mem_normal, mem_device, mem_strong})
    else $error("Bad region type.");
  a_word_lanes: assert property (mem_req && mem_write && mem_be == 4'hf |-> mem_addr[1:0] == 2'h0)
    else $error("Word write misaligned.");
  a_byte_lane: assert property (mem_req && mem_write && $countones(mem_be) == 1 |->
    mem_be == 4'h1 << mem_addr[1:0])
    else $error("Byte write wrong lane.");
  a_rsp_source: assert property (rsp_valid |-> $past(mem_rvalid))
    else $error("Response without answer.");
  a_rev_word: assert property (rev_op == byte_reverse_word_op |-> rev_out == {<<8{rev_in}})
    else $error("Word reverse wrong.");
  a_rev_signed: assert property (rev_op == byte_reverse_signed_half_op |->
    rev_out == {{16{rev_in[7]}}, rev_in[7:0], rev_in[15:8]})
    else $error("Signed half reverse wrong.");
  a_rev_packed: assert property (rev_op == byte_reverse_packed_halves_op |->
    rev_out == {rev_in[23:16], rev_in[31:24], rev_in[7:0], rev_in[15:8]})
    else $error("Packed reverse wrong.");
endmodule // lsu_properties

bind load_store_ordering_atomicity lsu_properties lsu_properties_inst (.*);

//--- bench/mem_model.sv
// Behavioural byte memory on the far side of the unit's system bus.
module mem_model (
  // Clock.
  input wire logic        sys_clk,
  // Bus from the unit.
  input wire logic        mem_req,
  output logic            mem_gnt,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_write,
  input wire logic [3:0]  mem_be,
  input wire logic [31:0] mem_wdata,
  output logic            mem_rvalid,
  output logic [31:0]     mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem_b [logic [31:0]];
  logic [31:0] a_q, d_q;
  logic [3:0]  be_q;
  logic        w_q, pend_q = 1'b0;
  int          wait_q;
  // Unwritten bytes hold a pattern derived from their address.
  function automatic logic [7:0] rd_byte(input logic [31:0] a);
    return mem_b.exists(a) ? mem_b[a] : a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  initial mem_gnt = 1'b0;
  initial mem_rvalid = 1'b0;
  initial mem_rdata = 32'h0;
  // Grant after a random stall, answer after a random wait, one transfer at a time.
  always @(posedge sys_clk) begin
    mem_gnt <= 1'b0;
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata; // Outside an answer the data lines invert each cycle, so a stale value shows every other cycle.
    if (mem_req && mem_gnt) begin
      a_q <= {mem_addr[31:2], 2'h0};
      w_q <= mem_write;
      be_q <= mem_be;
      d_q <= mem_wdata;
      wait_q <= $urandom_range(0, 3);
      pend_q <= 1'b1;
    end else if (pend_q && wait_q == 0) begin
      pend_q <= 1'b0;
      mem_rvalid <= 1'b1;
      for (int k = 0; k < 4; k++) begin
        if (w_q && be_q[k]) mem_b[a_q + k] = d_q[8*k +: 8];
        mem_rdata[8*k +: 8] <= rd_byte(a_q + k);
      end
    end else if (pend_q) begin
      wait_q <= wait_q - 1;
    end else if (mem_req && $urandom_range(0, 2) != 0) begin
      mem_gnt <= 1'b1;
    end
  end
endmodule // mem_model

//--- bench/test_load_store_ordering_atomicity.sv
// Self-checking bench for the load/store ordering and atomicity unit.
module test_load_store_ordering_atomicity;
  import lsu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // Inputs driven by the bench.
  logic          sys_clk = 1'b0, sys_rst = 1'b1, big_end_strap = 1'b0;
  logic          req_valid = 1'b0, req_share = 1'b0, fetch_valid = 1'b0;
  req_op_type    req_op = op_byte_load;
  mem_kind_type  req_kind = mem_normal;
  cache_pol_type req_cache = cache_none;
  rev_op_type    rev_op = byte_pass_op;
  logic [31:0]   req_addr = 32'h0, req_wdata = 32'h0, fetch_addr = 32'h0, rev_in = 32'h0;
  logic [4:0]    req_count = 5'h1;
  // Outputs of the unit and the memory.
  logic          req_ready, rsp_valid, rsp_last, align_fault, fetch_ready, instr_valid, instr_wide;
  logic          mem_req, mem_gnt, mem_write, mem_share, mem_rvalid;
  logic [31:0]   rsp_data, instr_data, rev_out, mem_addr, mem_wdata, mem_rdata;
  logic [3:0]    mem_be;
  mem_kind_type  mem_kind;
  cache_pol_type mem_cache;
  // Bench state.
  int            errors = 0, total_checks = 0;
  logic          be_q, flt;
  logic [4:0]    attr;
  logic [31:0]   got[$], addrs[$];

  load_store_ordering_atomicity #(.MAX_WORDS(16)) load_store_ordering_atomicity_inst (.*);
  mem_model mem_model_inst (.*);

  // Core clock, 5 ns period.
  always #2.5 sys_clk = ~sys_clk;

  // Comparison of one result, counted.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] mb(input logic [31:0] a);
    return mem_model_inst.rd_byte(a);
  endfunction
  // Element of sz bytes at a, mapped by the current endianness.
  function automatic logic [31:0] exp_load(input int sz, input logic [31:0] a);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < sz; k++) v[8*(be_q ? sz-1-k : k) +: 8] = mb(a + k);
    return v;
  endfunction
  function automatic logic [4:0] exp_attr(input mem_kind_type k, input logic sh, input cache_pol_type c);
    if (k == mem_strong) return {mem_strong, 1'b1, cache_none};
    if (k == mem_device) return {mem_device, sh, cache_none};
    return {mem_normal, sh, (c == 2'h3) ? cache_none : c};
  endfunction
  // One core request, then collection of bus grants and answers.
  task automatic do_req(input req_op_type op, input logic [31:0] a, input logic [31:0] wd, input logic [4:0] n,
                        input mem_kind_type k, input logic sh, input cache_pol_type c);
    int t;
    got.delete();
    addrs.delete();
    flt = 1'b0;
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= wd;
    req_count <= n;
    req_kind <= k;
    req_share <= sh;
    req_cache <= c;
    do @(posedge sys_clk); while (!req_ready);
    req_valid <= 1'b0;
    for (t = 0; t < 400; t++) begin
      @(posedge sys_clk);
      if (mem_req && mem_gnt) begin
        addrs.push_back(mem_addr);
        attr = {mem_kind, mem_share, mem_cache};
      end
      if (rsp_valid) got.push_back(rsp_data);
      flt = align_fault;
      if (align_fault || (rsp_valid && (rsp_last || op < op_multi_register_load))) break;
    end
    chk("completion", 32'h1, 32'(t < 400));
  endtask
  task automatic tend(input string name);
    $display("test %s done, mismatches so far %0d", name, errors);
  endtask
  // Reset with the strap, then wait past its capture edge.
  task automatic do_reset(input logic big);
    sys_rst <= 1'b1;
    big_end_strap <= big;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    be_q = big;
    chk("reset ready", 32'h1, 32'(req_ready));
    chk("reset attr", {27'h0, mem_strong, 1'b1, 2'h0}, {27'h0, mem_kind, mem_share, 2'h0});
    tend("reset");
  endtask
  task automatic run_rev();
    logic [31:0] v;
    for (int i = 0; i < 16; i++) begin
      v = (i < 4) ? 32'h1234_80ff : $urandom;
      rev_op <= rev_op_type'(i % 4);
      rev_in <= v;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk("rev_out", (i % 4 == 0) ? {<<8{v}} : (i % 4 == 1) ? {{16{v[7]}}, v[7:0], v[15:8]} :
          (i % 4 == 2) ? {v[23:16], v[31:24], v[7:0], v[15:8]} : v, rev_out);
    end
    tend("byte reverse");
  endtask
  // Random aligned single transfers over all kinds, sizes and attributes.
  task automatic run_data();
    req_op_type op;
    mem_kind_type k;
    cache_pol_type c;
    logic [31:0] a, wd;
    logic sh;
    repeat (24) begin
      op = req_op_type'($urandom_range(0, 5));
      k = mem_kind_type'($urandom_range(0, 2));
      c = cache_pol_type'($urandom_range(0, 3));
      sh = 1'($urandom_range(0, 1));
      a = 32'h1000 + ($urandom_range(0, 63) << (op >> 1));
      wd = $urandom;
      do_req(op, a, wd, 5'h1, k, sh, c);
      chk("fault", 32'h0, 32'(flt));
      chk("attributes", 32'(exp_attr(k, sh, c)), 32'(attr));
      if (op[0]) begin
        chk("stored byte", 32'(8'(wd >> (be_q ? (8 << (op >> 1)) - 8 : 0))), 32'(mb(a)));
        do_req(req_op_type'(op - 1), a, 32'h0, 5'h1, k, sh, c);
        chk("read back", wd & (32'hffff_ffff >> (32 - (8 << (op >> 1)))), got[0]);
      end else begin
        chk("load data", exp_load(1 << (op >> 1), a), got[0]);
      end
    end
    tend("data");
  endtask
  // Misaligned halfword, word and multi requests, then multi transfers.
  task automatic run_edges();
    logic [4:0] cnt[4] = '{5'h0, 5'h3, 5'h10, 5'h2};
    int m;
    for (int i = 0; i < 6; i++) begin
      do_req(req_op_type'(i + 2), 32'h1001 + 2 * (i % 2), 32'h0, 5'h1, mem_device, 1'b0, cache_none);
      chk("misaligned fault", 32'h1, 32'(flt));
      chk("misaligned issue", 32'h0, 32'(addrs.size()));
    end
    for (int i = 0; i < 4; i++) begin
      m = (cnt[i] == 5'h0) ? 1 : int'(cnt[i]);
      do_req(i == 3 ? op_multi_register_store : op_multi_register_load, 32'h1100, $urandom, cnt[i],
             mem_normal, 1'b1, cache_wback);
      chk("multi words", 32'(m), 32'(addrs.size()));
      for (int j = 0; j < m; j++) begin
        chk("multi addr", 32'h1100 + 4 * j, addrs[j]);
        if (i < 3) chk("multi data", exp_load(4, 32'h1100 + 4 * j), got[j]);
      end
    end
    tend("fault and multi");
  endtask
  // Narrow and wide fetches, both wide ones crossing a word boundary, always little endian.
  task automatic run_fetch();
    logic [7:0] hi[3] = '{8'hf8, 8'he0, 8'he8};
    logic [31:0] a;
    logic [15:0] lead;
    logic wide;
    for (int i = 0; i < 3; i++) begin
      a = 32'h2002 + 16 * i;
      mem_model_inst.mem_b[a + 1] = hi[i];
      lead = {mb(a + 1), mb(a)};
      wide = lead[15:13] == 3'h7 && lead[12:11] != 2'h0;
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      do @(posedge sys_clk); while (!fetch_ready);
      fetch_valid <= 1'b0;
      for (int t = 0; t < 400 && !instr_valid; t++) @(posedge sys_clk);
      chk("instr_wide", 32'(wide), 32'(instr_wide));
      chk("instr_data", wide ? {lead, mb(a + 3), mb(a + 2)} : {16'h0, lead}, instr_data);
    end
    tend("fetch");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence: little endian pass, then a second reset into big endian.
  initial begin
    void'($urandom(67835));
    for (int e = 0; e < 2; e++) begin
      do_reset(1'(e));
      run_rev();
      run_data();
      run_edges();
      run_fetch();
    end
    final_report();
  end
  // Watchdog, far past the run's length.
  initial begin
    #400000;
    errors++;
    final_report();
  end
endmodule // test_load_store_ordering_atomicity

//--- hw/lane_mapper.sv
// Byte lane mapper that applies endianness per element size.
module lane_mapper (
  mem_bus_if.mapper bus
);
  import lsu_pkg::*;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic       swap;

  // Extract the element from the bus word and order its bytes.
  always_comb begin
    b0 = bus.rdata_raw[7:0];
    b1 = bus.rdata_raw[15:8];
    b2 = bus.rdata_raw[23:16];
    b3 = bus.rdata_raw[31:24];
    swap = bus.big_end && !bus.is_fetch;
    bus.rdata = 32'h0;
    case (bus.size)
      // A byte has no internal order; its lane follows its address.
      size_byte_type_v: bus.rdata = {24'h0, bus.rdata_raw[8*bus.addr[1:0] +: 8]};
      size_half_type_v: begin
        if (bus.addr[1]) begin
          bus.rdata = swap ? {16'h0, b2, b3} : {16'h0, b3, b2};
        end else begin
          bus.rdata = swap ? {16'h0, b0, b1} : {16'h0, b1, b0};
        end
      end
      default: begin
        bus.rdata = swap ? {b0, b1, b2, b3} : bus.rdata_raw;
      end
    endcase
  end
endmodule : lane_mapper

//--- hw/load_store_ordering_atomicity.sv
// Load/store unit with fetch pairing, endianness and atomic transfers.
// Summary of operation
// - Instructions are fetched on halfword boundaries; 32-bit ones as two halfwords.
// - Leading halfword comes from the lower address, trailing from the next.
// - Endianness is applied per element: byte, halfword or word.
// - Multi-register loads, stores, pushes and pops use word elements.
// - One operation reverses all four bytes of a word.
// - One operation swaps the low halfword bytes and sign-extends.
// - One operation swaps bytes within each packed halfword.
// - No exclusive access support and no exclusive monitor.
// - Each region has exactly one type: Normal, Device or Strongly-ordered.
// - Strongly-ordered regions are always Shareable.
// - Strongly-ordered accesses stay in program order.
// - Normal has shareability and cacheability; Device has shareability.
// - An atomic operand always holds one write's whole value.
// - An atomic read sees the whole old or whole new value.
// - Atomic: bytes, aligned halfwords, aligned words only.
// - Multi-register transfers issue as aligned single-word transfers.
// - No atomicity across several words of a multi-register sequence.
// - Non-atomic accesses split into smaller atomic ones, bytes at least; misaligned ones fault here instead.
// - Linefills and evictions do not change transfer atomicity.
// - Each fetched halfword is single-copy atomic.
// - Endianness applies only to data; fetches are little endian.
// - Misaligned data accesses raise a fault.
// - Little endian puts lowest address least significant; big endian most.
module load_store_ordering_atomicity #(
  parameter int unsigned MAX_WORDS = 16
) (
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // Endianness strap, sampled after reset release.
  input  wire logic                   big_end_strap,
  // Data request from the core.
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire lsu_pkg::req_op_type    req_op,
  input  wire logic [31:0]            req_addr,
  input  wire logic [31:0]            req_wdata,
  input  wire logic [4:0]             req_count,
  input  wire lsu_pkg::mem_kind_type  req_kind,
  input  wire logic                   req_share,
  input  wire lsu_pkg::cache_pol_type req_cache,
  // Data response to the core.
  output logic                        rsp_valid,
  output logic [31:0]                 rsp_data,
  output logic                        rsp_last,
  output logic                        align_fault,
  // Instruction fetch request and response.
  input  wire logic                   fetch_valid,
  output logic                        fetch_ready,
  input  wire logic [31:0]            fetch_addr,
  output logic                        instr_valid,
  output logic [31:0]                 instr_data,
  output logic                        instr_wide,
  // Register byte operation.
  input  wire lsu_pkg::rev_op_type    rev_op,
  input  wire logic [31:0]            rev_in,
  output logic [31:0]                 rev_out,
  // System memory bus.
  output logic                        mem_req,
  input  wire logic                   mem_gnt,
  output logic [31:0]                 mem_addr,
  output logic                        mem_write,
  output logic [3:0]                  mem_be,
  output logic [31:0]                 mem_wdata,
  output lsu_pkg::mem_kind_type       mem_kind,
  output logic                        mem_share,
  output lsu_pkg::cache_pol_type      mem_cache,
  input  wire logic                   mem_rvalid,
  input  wire logic [31:0]            mem_rdata
);
  import lsu_pkg::*;

  typedef enum {st_idle, st_data, st_dwait, st_fetch, st_fwait} state_type;

  state_type     state_q;
  logic          big_end_q;
  logic          strap_s1_q;
  logic          strap_s2_q;
  logic          strap_taken_q;
  req_op_type    op_q;
  logic [31:0]   addr_q;
  logic [31:0]   wdata_q;
  logic [4:0]    left_q;
  logic          second_q;
  logic [15:0]   lead_q;
  logic [1:0]    strap_prime_q;
  elem_size_type size_d;
  logic          is_write_d;
  logic          misalign_d;
  logic          fetch_mode;
  logic [7:0]    rv0;
  logic [7:0]    rv1;
  logic [7:0]    rv2;
  logic [7:0]    rv3;
  logic [15:0]   fetched_half;

  mem_bus_if bus ();

  lane_mapper u_lane_mapper (
    .bus (bus)
  );

  // Strap synchroniser; the second stage alone is read.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strap_s1_q    <= 1'b0;
      strap_s2_q    <= 1'b0;
      strap_prime_q <= 2'h0;
    end else begin
      strap_s1_q    <= big_end_strap;
      strap_s2_q    <= strap_s1_q;
      strap_prime_q <= {strap_prime_q[0], 1'b1};
    end
  end

  // Endianness is captured once after reset and then holds.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      big_end_q     <= RST_BIG_END;
      strap_taken_q <= 1'b0;
    end else if (strap_prime_q[1] && !strap_taken_q) begin
      big_end_q     <= strap_s2_q;
      strap_taken_q <= 1'b1;
    end
  end

  // Decode element size and direction of the incoming request.
  always_comb begin
    is_write_d = 1'b0;
    case (req_op)
      op_byte_load:            size_d = size_byte_type_v;
      op_byte_store: begin
        size_d     = size_byte_type_v;
        is_write_d = 1'b1;
      end
      op_halfword_load:        size_d = size_half_type_v;
      op_halfword_store: begin
        size_d     = size_half_type_v;
        is_write_d = 1'b1;
      end
      op_multi_register_store: begin
        size_d     = size_word_type_v;
        is_write_d = 1'b1;
      end
      op_word_store: begin
        size_d     = size_word_type_v;
        is_write_d = 1'b1;
      end
      default:                 size_d = size_word_type_v;
    endcase
  end

  // Misaligned data accesses are refused with a fault instead of being split.
  always_comb begin
    case (size_d)
      size_half_type_v: misalign_d = req_addr[0];
      size_word_type_v: misalign_d = |req_addr[1:0];
      default:          misalign_d = 1'b0;
    endcase
  end

  // Register byte operations are purely combinational.
  always_comb begin
    rv0 = rev_in[7:0];
    rv1 = rev_in[15:8];
    rv2 = rev_in[23:16];
    rv3 = rev_in[31:24];
    case (rev_op)
      byte_reverse_word_op:          rev_out = {rv0, rv1, rv2, rv3};
      byte_reverse_signed_half_op:   rev_out = {{16{rv0[7]}}, rv0, rv1};
      byte_reverse_packed_halves_op: rev_out = {rv2, rv3, rv0, rv1};
      default:                       rev_out = rev_in;
    endcase
  end

  // Only one access is outstanding at a time, so every region keeps program order.
  assign req_ready   = (state_q == st_idle);
  assign fetch_ready = (state_q == st_idle) && !req_valid;
  assign fetch_mode  = (state_q == st_fetch) || (state_q == st_fwait);

  // Drive the lane mapper with the current transfer.
  assign bus.addr      = addr_q;
  assign bus.size      = fetch_mode ? size_half_type_v : op_size(op_q);
  assign bus.big_end   = big_end_q;
  assign bus.is_fetch  = fetch_mode;
  assign bus.rdata_raw = mem_rdata;
  assign fetched_half  = bus.rdata[15:0];

  function automatic elem_size_type op_size(input req_op_type op);
    case (op)
      op_byte_load, op_byte_store:         op_size = size_byte_type_v;
      op_halfword_load, op_halfword_store: op_size = size_half_type_v;
      default:                             op_size = size_word_type_v;
    endcase
  endfunction

  // Bus request lines follow the state.
  assign mem_req = (state_q == st_data) || (state_q == st_fetch);

  // Byte enables cover exactly one aligned element, so each transfer is atomic.
  always_comb begin
    mem_be = 4'h0;
    if (fetch_mode) begin
      mem_be = addr_q[1] ? 4'hc : 4'h3;
    end else begin
      case (op_size(op_q))
        size_byte_type_v: mem_be = 4'h1 << addr_q[1:0];
        size_half_type_v: mem_be = addr_q[1] ? 4'hc : 4'h3;
        default:          mem_be = 4'hf;
      endcase
    end
  end

  // Store data is placed into its byte lanes with the selected endianness.
  always_comb begin
    case (op_size(op_q))
      size_byte_type_v: mem_wdata = {4{wdata_q[7:0]}};
      size_half_type_v: mem_wdata = big_end_q ? {2{wdata_q[7:0], wdata_q[15:8]}} : {2{wdata_q[15:0]}};
      default:          mem_wdata = big_end_q ? {wdata_q[7:0], wdata_q[15:8], wdata_q[23:16], wdata_q[31:24]}
                                              : wdata_q;
    endcase
  end

  assign mem_addr  = fetch_mode ? {addr_q[31:1], 1'b0} : addr_q;
  assign mem_write = !fetch_mode && (op_q == op_byte_store || op_q == op_halfword_store ||
                                     op_q == op_word_store || op_q == op_multi_register_store);

  // Region attributes, latched when an aligned request is taken.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_kind  <= mem_strong;
      mem_share <= 1'b1;
      mem_cache <= cache_none;
    end else if (req_valid && req_ready && !misalign_d) begin
      mem_kind  <= (req_kind == mem_device || req_kind == mem_strong) ? req_kind : mem_normal;
      mem_share <= (req_kind == mem_strong) ? 1'b1 : req_share;
      mem_cache <= (req_kind == mem_normal && req_cache != 2'h3) ? req_cache : cache_none;
    end
  end

  // Sequencer for data words and fetch halfwords.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q  <= st_idle;
      op_q     <= op_word_load;
      addr_q   <= 32'h0;
      wdata_q  <= 32'h0;
      left_q   <= 5'h0;
      second_q <= 1'b0;
      lead_q   <= 16'h0;
    end else begin
      case (state_q)
        st_idle: begin
          second_q <= 1'b0;
          if (req_valid && !misalign_d) begin
            state_q <= st_data;
            op_q    <= req_op;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            left_q  <= (req_count == 5'h0) ? 5'h1 : req_count;
          end else if (fetch_valid && !req_valid) begin
            state_q <= st_fetch;
            addr_q  <= {fetch_addr[31:1], 1'b0};
          end
        end
        st_data: if (mem_gnt) state_q <= st_dwait;
        st_dwait: begin
          if (mem_rvalid) begin
            // Each word of a multi-register sequence is its own atomic transfer.
            if (left_q > 5'h1) begin
              left_q  <= left_q - 5'h1;
              addr_q  <= addr_q + 32'h4;
              state_q <= st_data;
            end else begin
              state_q <= st_idle;
            end
          end
        end
        st_fetch: if (mem_gnt) state_q <= st_fwait;
        st_fwait: begin
          if (mem_rvalid) begin
            // A leading halfword with top bits 111xx other than 11100 starts a wide instruction.
            if (!second_q && fetched_half[15:13] == 3'h7 && fetched_half[12:11] != 2'h0) begin
              lead_q   <= fetched_half;
              second_q <= 1'b1;
              addr_q   <= addr_q + 32'h2;
              state_q  <= st_fetch;
            end else begin
              second_q <= 1'b0;
              state_q  <= st_idle;
            end
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // Data response and fault reporting.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid   <= 1'b0;
      rsp_data    <= 32'h0;
      rsp_last    <= 1'b0;
      align_fault <= 1'b0;
    end else begin
      rsp_valid   <= (state_q == st_dwait) && mem_rvalid;
      rsp_last    <= (state_q == st_dwait) && mem_rvalid && (left_q <= 5'h1);
      align_fault <= req_valid && req_ready && misalign_d;
      if (state_q == st_dwait && mem_rvalid) begin
        rsp_data <= bus.rdata;
      end
    end
  end

  // Instruction response: leading halfword in the upper half of a wide instruction.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      instr_valid <= 1'b0;
      instr_data  <= 32'h0;
      instr_wide  <= 1'b0;
    end else begin
      instr_valid <= 1'b0;
      if (state_q == st_fwait && mem_rvalid) begin
        if (second_q) begin
          instr_valid <= 1'b1;
          instr_data  <= {lead_q, fetched_half};
          instr_wide  <= 1'b1;
        end else if (!(fetched_half[15:13] == 3'h7 && fetched_half[12:11] != 2'h0)) begin
          instr_valid <= 1'b1;
          instr_data  <= {16'h0, fetched_half};
          instr_wide  <= 1'b0;
        end
      end
    end
  end
endmodule : load_store_ordering_atomicity

//--- hw/lsu_pkg.sv
// Package with shared types and constants for the load/store ordering unit.
package lsu_pkg;
  localparam logic RST_BIG_END = 1'b0;

  // Element size of one transfer.
  typedef enum logic [1:0] {
    size_byte_type_v = 2'h0,
    size_half_type_v = 2'h1,
    size_word_type_v = 2'h2
  } elem_size_type;

  // Memory region types; exactly one applies per region.
  typedef enum logic [1:0] {
    mem_normal   = 2'h0,
    mem_device   = 2'h1,
    mem_strong   = 2'h2
  } mem_kind_type;

  // Cacheability of a Normal region.
  typedef enum logic [1:0] {
    cache_none   = 2'h0,
    cache_wthru  = 2'h1,
    cache_wback  = 2'h2
  } cache_pol_type;

  // Request kinds issued by the core.
  typedef enum logic [2:0] {
    op_byte_load             = 3'h0,
    op_byte_store            = 3'h1,
    op_halfword_load         = 3'h2,
    op_halfword_store        = 3'h3,
    op_word_load             = 3'h4,
    op_word_store            = 3'h5,
    op_multi_register_load   = 3'h6,
    op_multi_register_store  = 3'h7
  } req_op_type;

  // Register byte operations.
  typedef enum logic [1:0] {
    byte_reverse_word_op          = 2'h0,
    byte_reverse_signed_half_op   = 2'h1,
    byte_reverse_packed_halves_op = 2'h2,
    byte_pass_op                  = 2'h3
  } rev_op_type;
endpackage : lsu_pkg

//--- hw/mem_bus_if.sv
// Interface carrying one memory bus transfer between the sequencer and the lane mapper.
interface mem_bus_if;
  import lsu_pkg::*;
  logic [31:0]   addr;
  logic [31:0]   rdata_raw;
  logic [31:0]   rdata;
  elem_size_type size;
  logic          big_end;
  logic          is_fetch;
  modport mapper (input addr, input size, input big_end, input is_fetch, input rdata_raw, output rdata);
  modport seq (output addr, output size, output big_end, output is_fetch, output rdata_raw, input rdata);
endinterface : mem_bus_if
